// >>> rtl/iep_pkg.sv
// Shared constants and carrier types for the interrupt enable and priority block
package iep_pkg;

  // Register addresses on the special-function port
  localparam logic [7:0] ADDR_ENABLE   = 8'hA8;
  localparam logic [7:0] ADDR_PRIORITY = 8'h88;
  localparam logic [7:0] ADDR_STATUS   = 8'hE8;
  localparam logic [7:0] ADDR_MASK     = 8'hE9;

  // Source bit positions, shared by the enable and the priority register
  localparam int SRC_EXT_A    = 0;
  localparam int SRC_TIMER_A  = 1;
  localparam int SRC_EXT_B    = 2;
  localparam int SRC_TIMER_B  = 3;
  localparam int SRC_SERIAL0  = 4;
  localparam int SRC_SERIAL1  = 6;
  localparam int BIT_GLOBAL   = 7;

  // Writable bits; everything else is reserved and reads as zero
  localparam logic [7:0] ENABLE_WMASK   = 8'hDF;
  localparam logic [7:0] PRIORITY_WMASK = 8'h5F;
  localparam logic [7:0] SOURCE_MASK    = 8'h5F;
  localparam logic [7:0] STATUS_WMASK   = 8'h07;

  // Event bits of the status register
  localparam int EV_LOW_TAKEN  = 0;
  localparam int EV_HIGH_TAKEN = 1;
  localparam int EV_PREEMPT    = 2;

  // Reset values
  localparam logic [7:0] ENABLE_RESET   = 8'h00;
  localparam logic [7:0] PRIORITY_RESET = 8'h00;
  localparam logic [7:0] STATUS_RESET   = 8'h00;
  localparam logic [7:0] MASK_RESET     = 8'h00;

  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } iep_bus_type;

  typedef struct packed {
    logic       valid;
    logic       level;
    logic [2:0] src;
  } iep_req_type;

endpackage : iep_pkg

// >>> rtl/iep_pick.sv
// Finds the lowest set bit of a request vector
`timescale 1ns/1ps
`default_nettype none

module iep_pick (
  input  wire logic [7:0] vec,
  output logic      [2:0] idx,
  output logic            any
);

  // Downward scan so the lowest position wins, as in the classic polling order
  always_comb
  begin
    idx = 3'h0;
    any = 1'b0;
    for (int i = 7; i >= 0; i--)
    begin
      if (vec[i])
      begin
        idx = 3'(i);
        any = 1'b1;
      end
    end
  end

endmodule : iep_pick

`default_nettype wire

// >>> rtl/iep_top.sv
// Interrupt enable, priority and nesting control for the 8051-style core
//
// Contract
// R01: Enable bit 4 gates the serial0 request toward the core.
// R02: Enable bit 3 gates the timer_b request toward the core.
// R03: Enable bit 2 gates the ext_b request toward the core.
// R04: Enable bit 1 gates the timer_a request toward the core.
// R05: Enable bit 0 gates the ext_a request toward the core.
// R06: Priority register at 0x88, one bit per source, one means high.
// R07: Priority bit 6 selects the serial1 level.
// R08: Priority bits 3, 4, 2, 1 set timer_b, serial0, ext_b, timer_a levels.
// R09: Enable bit 7 is a global enable; clear masks every source.
// R10: Enable bit 6 gates the serial1 request toward the core.
// R11: All bits reset to zero; reserved bits read zero, ignore writes.
// R12: High served first, preempts low service, never same level.
`timescale 1ns/1ps
`default_nettype none

module iep_top (
  input  wire logic              sys_clk,
  input  wire logic              resetn,
  input  wire iep_pkg::iep_bus_type bus,
  output logic      [7:0]        rdata,
  input  wire logic              ext_a_pin,
  input  wire logic              ext_b_pin,
  input  wire logic              timer_a_irq,
  input  wire logic              timer_b_irq,
  input  wire logic              serial0_irq,
  input  wire logic              serial1_irq,
  output iep_pkg::iep_req_type   core_req,
  input  wire logic              core_ack,
  input  wire logic              core_reti,
  output logic                   irq_out
);

  logic [7:0]           enable_reg;
  logic [7:0]           enable_next;
  logic [7:0]           priority_reg;
  logic [7:0]           priority_next;
  logic [7:0]           status_reg;
  logic [7:0]           status_next;
  logic [7:0]           mask_reg;
  logic [7:0]           mask_next;
  logic [7:0]           rdata_reg;
  logic [7:0]           rdata_next;
  iep_pkg::iep_req_type req_reg;
  iep_pkg::iep_req_type req_next;
  logic                 hi_act_reg;
  logic                 hi_act_next;
  logic                 lo_act_reg;
  logic                 lo_act_next;
  logic                 irq_reg;
  logic [1:0]           ext_a_sync_reg;
  logic [1:0]           ext_b_sync_reg;

  // Pins from outside pass two flops before anything reads them
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      ext_a_sync_reg <= 2'h0;
      ext_b_sync_reg <= 2'h0;
    end
    else
    begin
      ext_a_sync_reg <= {ext_a_sync_reg[0], ext_a_pin};
      ext_b_sync_reg <= {ext_b_sync_reg[0], ext_b_pin};
    end
  end

  wire [7:0] raw_req;
  assign raw_req[iep_pkg::SRC_EXT_A]   = ext_a_sync_reg[1];
  assign raw_req[iep_pkg::SRC_TIMER_A] = timer_a_irq;
  assign raw_req[iep_pkg::SRC_EXT_B]   = ext_b_sync_reg[1];
  assign raw_req[iep_pkg::SRC_TIMER_B] = timer_b_irq;
  assign raw_req[iep_pkg::SRC_SERIAL0] = serial0_irq;
  assign raw_req[5]                    = 1'b0;
  assign raw_req[iep_pkg::SRC_SERIAL1] = serial1_irq;
  assign raw_req[7]                    = 1'b0;

  // Address decode
  wire hit_enable   = (bus.addr == iep_pkg::ADDR_ENABLE);
  wire hit_priority = (bus.addr == iep_pkg::ADDR_PRIORITY);
  wire hit_status   = (bus.addr == iep_pkg::ADDR_STATUS);
  wire hit_mask     = (bus.addr == iep_pkg::ADDR_MASK);

  // R11 reserved bits
  assign enable_next   = (bus.wr && hit_enable)
                       ? (bus.wdata & iep_pkg::ENABLE_WMASK) : enable_reg;
  assign priority_next = (bus.wr && hit_priority)
                       ? (bus.wdata & iep_pkg::PRIORITY_WMASK) : priority_reg;
  assign mask_next     = (bus.wr && hit_mask)
                       ? (bus.wdata & iep_pkg::STATUS_WMASK) : mask_reg;

  wire [7:0] read_mux = hit_enable   ? enable_reg   :
                        hit_priority ? priority_reg :
                        hit_status   ? status_reg   :
                        hit_mask     ? mask_reg     : 8'h00;
  // Unmapped reads answer zero
  assign rdata_next = bus.rd ? read_mux : 8'h00;

  // R01 R02 R03 R04 R05 R10 source gates
  wire [7:0] gated = raw_req & enable_reg & iep_pkg::SOURCE_MASK;
  // R09 global gate
  wire       global_on = enable_reg[iep_pkg::BIT_GLOBAL];
  // R06 R07 R08 level split
  wire [7:0] hi_pend = global_on ? (gated & priority_reg) : 8'h00;
  wire [7:0] lo_pend = global_on ? (gated & ~priority_reg) : 8'h00;

  wire [2:0] hi_idx;
  wire       hi_any;
  wire [2:0] lo_idx;
  wire       lo_any;

  iep_pick u_pick_hi (
    .vec (hi_pend),
    .idx (hi_idx),
    .any (hi_any)
  );

  iep_pick u_pick_lo (
    .vec (lo_pend),
    .idx (lo_idx),
    .any (lo_any)
  );

  // R12 nesting: high only when no high active, low only when idle
  wire allow_hi = !hi_act_reg;
  wire allow_lo = !hi_act_reg && !lo_act_reg;
  wire take_hi  = allow_hi && hi_any;
  wire take_lo  = allow_lo && lo_any && !hi_any;

  // Request withdrawn in the ack cycle, since the nesting state lags by one
  always_comb
  begin
    req_next = '0;
    if (!core_ack)
    begin
      if (take_hi)
      begin
        req_next.valid = 1'b1;
        req_next.level = 1'b1;
        req_next.src   = hi_idx;
      end
      else if (take_lo)
      begin
        req_next.valid = 1'b1;
        req_next.level = 1'b0;
        req_next.src   = lo_idx;
      end
    end
  end

  wire ack_hi = core_ack && req_reg.valid && req_reg.level;
  wire ack_lo = core_ack && req_reg.valid && !req_reg.level;

  // R12 in-service tracking; return unwinds the innermost level first
  assign hi_act_next = ack_hi ? 1'b1 : ((core_reti && hi_act_reg) ? 1'b0 : hi_act_reg);
  assign lo_act_next = ack_lo ? 1'b1
                     : ((core_reti && !hi_act_reg) ? 1'b0 : lo_act_reg);

  wire [7:0] events;
  assign events[iep_pkg::EV_LOW_TAKEN]  = ack_lo;
  assign events[iep_pkg::EV_HIGH_TAKEN] = ack_hi;
  assign events[iep_pkg::EV_PREEMPT]    = ack_hi && lo_act_reg;
  assign events[7:3]                    = 5'h00;

  // Set wins over a same-cycle write-one clear
  wire [7:0] w1c = (bus.wr && hit_status) ? (bus.wdata & iep_pkg::STATUS_WMASK) : 8'h00;
  assign status_next = (status_reg & ~w1c) | events;

  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      enable_reg   <= iep_pkg::ENABLE_RESET;
      priority_reg <= iep_pkg::PRIORITY_RESET;
      status_reg   <= iep_pkg::STATUS_RESET;
      mask_reg     <= iep_pkg::MASK_RESET;
      rdata_reg    <= 8'h00;
      req_reg      <= '0;
      hi_act_reg   <= 1'b0;
      lo_act_reg   <= 1'b0;
      irq_reg      <= 1'b0;
    end
    else
    begin
      enable_reg   <= enable_next;
      priority_reg <= priority_next;
      status_reg   <= status_next;
      mask_reg     <= mask_next;
      rdata_reg    <= rdata_next;
      req_reg      <= req_next;
      hi_act_reg   <= hi_act_next;
      lo_act_reg   <= lo_act_next;
      irq_reg      <= |(status_reg & mask_reg);
    end
  end

  assign rdata    = rdata_reg;
  assign core_req = req_reg;
  assign irq_out  = irq_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  // R09 global gate
  global_gate_a: assert property ( // R09
    req_reg.valid |-> $past(enable_reg[iep_pkg::BIT_GLOBAL]))
    else $error("request presented while global enable clear");

  // R01 R02 R03 R04 R05 R10 source gates
  source_gate_a: assert property ( // R01 R02 R03 R04 R05 R10
    req_reg.valid |-> |($past(raw_req & enable_reg) & (8'h01 << req_reg.src)))
    else $error("request from a disabled or idle source");

  // R06 R07 R08 level choice
  level_match_a: assert property ( // R06 R07 R08
    req_reg.valid |-> req_reg.level == |($past(priority_reg) & (8'h01 << req_reg.src)))
    else $error("request level differs from its priority bit");

  // R12 high first
  high_first_a: assert property ( // R12
    req_reg.valid && !req_reg.level |-> !$past(hi_any))
    else $error("low request presented over a pending high one");

  // R12 nesting limits
  no_nesting_a: assert property ( // R12
    req_reg.valid |-> !$past(hi_act_reg) && (req_reg.level || !$past(lo_act_reg)))
    else $error("request would nest at the same or lower level");

  // R12 ack withdraws
  ack_drop_a: assert property ( // R12
    core_ack |=> !req_reg.valid)
    else $error("request still presented after acknowledge");

  // R11 reserved bits
  reserved_zero_a: assert property ( // R11
    enable_reg[5] == 1'b0 && priority_reg[7] == 1'b0 && priority_reg[5] == 1'b0)
    else $error("reserved bit holds a one");

  // R06 priority readback
  prio_read_a: assert property ( // R06
    bus.rd && hit_priority |=> rdata == $past(priority_reg))
    else $error("priority register read returned wrong data");

  irq_follow_a: assert property (
    ##1 irq_out == $past(|(status_reg & mask_reg)))
    else $error("interrupt output does not follow masked status");

  // R01 serial0 gate
  serial0_gate_a: assert property ( // R01
    req_reg.valid && req_reg.src == 3'(iep_pkg::SRC_SERIAL0)
      |-> $past(enable_reg[iep_pkg::SRC_SERIAL0]))
    else $error("serial0 request passed while its enable bit is clear");

  // R02 timer_b gate
  timer_b_gate_a: assert property ( // R02
    req_reg.valid && req_reg.src == 3'(iep_pkg::SRC_TIMER_B)
      |-> $past(enable_reg[iep_pkg::SRC_TIMER_B]))
    else $error("timer_b request passed while its enable bit is clear");

  // R03 ext_b gate
  ext_b_gate_a: assert property ( // R03
    req_reg.valid && req_reg.src == 3'(iep_pkg::SRC_EXT_B)
      |-> $past(enable_reg[iep_pkg::SRC_EXT_B]))
    else $error("ext_b request passed while its enable bit is clear");

  // R04 timer_a gate
  timer_a_gate_a: assert property ( // R04
    req_reg.valid && req_reg.src == 3'(iep_pkg::SRC_TIMER_A)
      |-> $past(enable_reg[iep_pkg::SRC_TIMER_A]))
    else $error("timer_a request passed while its enable bit is clear");

  // R05 ext_a gate
  ext_a_gate_a: assert property ( // R05
    req_reg.valid && req_reg.src == 3'(iep_pkg::SRC_EXT_A)
      |-> $past(enable_reg[iep_pkg::SRC_EXT_A]))
    else $error("ext_a request passed while its enable bit is clear");

  // R10 serial1 gate
  serial1_gate_a: assert property ( // R10
    req_reg.valid && req_reg.src == 3'(iep_pkg::SRC_SERIAL1)
      |-> $past(enable_reg[iep_pkg::SRC_SERIAL1]))
    else $error("serial1 request passed while its enable bit is clear");

  // R07 serial1 level
  serial1_level_a: assert property ( // R07
    req_reg.valid && req_reg.src == 3'(iep_pkg::SRC_SERIAL1)
      |-> req_reg.level == $past(priority_reg[iep_pkg::SRC_SERIAL1]))
    else $error("serial1 request level differs from its priority bit");

  // R11 reset values
  reset_zero_a: assert property ( // R11
    $rose(resetn) |-> enable_reg == iep_pkg::ENABLE_RESET
      && priority_reg == iep_pkg::PRIORITY_RESET && status_reg == iep_pkg::STATUS_RESET
      && mask_reg == iep_pkg::MASK_RESET && !req_reg.valid && !irq_out)
    else $error("state not cleared by reset");

  // R11 reserved event bits
  status_reserved_a: assert property ( // R11
    status_reg[7:3] == 5'h00 && mask_reg[7:3] == 5'h00)
    else $error("reserved status or mask bit holds a one");

  // R12 high presented
  high_present_a: assert property ( // R12
    $past(hi_any && allow_hi && !core_ack) |-> req_reg.valid && req_reg.level)
    else $error("pending high request not presented");

  // R12 low presented
  low_present_a: assert property ( // R12
    $past(lo_any && !hi_any && allow_lo && !core_ack)
      |-> req_reg.valid && !req_reg.level)
    else $error("pending low request not presented");

  // R12 service marks
  service_mark_a: assert property ( // R12
    (ack_hi |=> hi_act_reg) and (ack_lo |=> lo_act_reg))
    else $error("acknowledged level not marked in service");

  // R06 priority write
  prio_write_a: assert property ( // R06 R11
    bus.wr && hit_priority |=> priority_reg == ($past(bus.wdata) & iep_pkg::PRIORITY_WMASK))
    else $error("priority write not stored as written");

  // Set wins over clear
  event_sticky_a: assert property (
    events != 8'h00 |=> (status_reg & $past(events)) == $past(events))
    else $error("status event lost");

  // Read data only after a read
  read_idle_a: assert property (
    !bus.rd |=> rdata == 8'h00)
    else $error("read data present without a read");

  preempt_c: cover property (ack_lo ##[1:20] ack_hi);
  low_take_c: cover property (ack_lo);
  reti_c: cover property (hi_act_reg && lo_act_reg ##1 core_reti);
  high_take_c: cover property (ack_hi);
  high_held_c: cover property (hi_act_reg && hi_any);

endmodule : iep_top

`default_nettype wire

// >>> sim/iep_core_model.sv
// Core acknowledge model for the interrupt request port
`timescale 1ns/1ps
`default_nettype none

module iep_core_model (
  input  wire logic                 sys_clk,
  input  wire logic                 resetn,
  input  wire logic                 auto_en,
  input  wire logic [3:0]           dly,
  input  wire iep_pkg::iep_req_type core_req,
  output logic                      core_ack
);
  logic [3:0] wait_reg;

  // one request taken at a time
  always_ff @(posedge sys_clk)
  begin
    if (!resetn)
    begin
      wait_reg <= 4'h0;
      core_ack <= 1'b0;
    end
    else
    begin
      // Count only while answering, so dly sets the real wait
      wait_reg <= (auto_en && core_req.valid && !core_ack) ? wait_reg + 4'h1 : 4'h0;
      // Ack only while valid; dly makes a slow core
      core_ack <= auto_en && core_req.valid && !core_ack && (wait_reg >= dly);
    end
  end
endmodule : iep_core_model
`default_nettype wire

// >>> sim/iep_tb_top.sv
// Self-checking bench for the interrupt enable and priority block
`timescale 1ns/1ps
`default_nettype none

module iep_tb_top;
  logic                 sys_clk = 1'b0;
  logic                 resetn = 1'b0;
  iep_pkg::iep_bus_type bus = '0;
  logic [7:0]           rdata;
  logic [7:0]           src_vec = 8'h00;
  iep_pkg::iep_req_type core_req;
  logic                 core_ack;
  logic                 core_reti = 1'b0;
  logic                 irq_out;
  logic                 auto_en = 1'b0;
  logic [3:0]           dly = 4'h0;
  logic [7:0]           pri;
  int                   fail_count = 0;
  int                   checked = 0;
  int                   idx [6] = '{0, 1, 2, 3, 4, 6};

  always #50 sys_clk = ~sys_clk;

  iep_top u_dut (.sys_clk(sys_clk), .resetn(resetn), .bus(bus), .rdata(rdata),
    .ext_a_pin(src_vec[0]), .timer_a_irq(src_vec[1]), .ext_b_pin(src_vec[2]),
    .timer_b_irq(src_vec[3]), .serial0_irq(src_vec[4]), .serial1_irq(src_vec[6]),
    .core_req(core_req), .core_ack(core_ack), .core_reti(core_reti), .irq_out(irq_out));

  iep_core_model u_core (.sys_clk(sys_clk), .resetn(resetn), .auto_en(auto_en),
    .dly(dly), .core_req(core_req), .core_ack(core_ack));

  task automatic close_out;
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp

  // Level and source only matter while valid
  task automatic cmp_req(input logic v, input logic l, input logic [2:0] s);
    if (v)
      cmp({3'h0, core_req}, {3'h0, v, l, s});
    else
      cmp({7'h0, core_req.valid}, 8'h00);
  endtask : cmp_req

  // Reserved bits read back as zero
  function automatic logic [7:0] kept(input logic [7:0] a, input logic [7:0] d);
    if (a == iep_pkg::ADDR_ENABLE)
      return d & iep_pkg::ENABLE_WMASK;
    return d & iep_pkg::PRIORITY_WMASK;
  endfunction : kept

  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask : cyc

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    bus <= '{1'b1, 1'b0, a, d};
    @(posedge sys_clk);
    bus.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    bus <= '{1'b0, 1'b1, a, 8'h00};
    @(posedge sys_clk);
    bus.rd <= 1'b0;
    #1;
    cmp(rdata, e);
  endtask : rd

  task automatic reti;
    @(posedge sys_clk);
    core_reti <= 1'b1;
    @(posedge sys_clk);
    core_reti <= 1'b0;
  endtask : reti

  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    close_out();
  end

  initial
  begin
    void'($urandom(45));
    repeat (16) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(iep_pkg::ADDR_ENABLE, 8'h00);
    rd(iep_pkg::ADDR_PRIORITY, 8'h00);
    rd(iep_pkg::ADDR_STATUS, 8'h00);
    rd(iep_pkg::ADDR_MASK, 8'h00);
    rd(8'h3C, 8'h00);
    cyc(1);
    cmp(rdata, 8'h00);
    repeat (6)
    begin
      pri = 8'($urandom);
      wr(iep_pkg::ADDR_ENABLE, pri);
      rd(iep_pkg::ADDR_ENABLE, kept(iep_pkg::ADDR_ENABLE, pri));
      wr(iep_pkg::ADDR_PRIORITY, ~pri);
      rd(iep_pkg::ADDR_PRIORITY, kept(iep_pkg::ADDR_PRIORITY, ~pri));
    end
    foreach (idx[i])
    begin
      pri = 8'($urandom) & iep_pkg::PRIORITY_WMASK;
      wr(iep_pkg::ADDR_PRIORITY, pri);
      wr(iep_pkg::ADDR_ENABLE, 8'hDF ^ (8'h01 << idx[i]));
      src_vec <= 8'h01 << idx[i];
      cyc(5);
      cmp_req(1'b0, 1'b0, 3'h0);
      wr(iep_pkg::ADDR_ENABLE, 8'h80 | (8'h01 << idx[i]));
      cyc(5);
      cmp_req(1'b1, pri[idx[i]], 3'(idx[i]));
      wr(iep_pkg::ADDR_ENABLE, 8'h01 << idx[i]);
      cyc(5);
      cmp_req(1'b0, 1'b0, 3'h0);
      src_vec <= 8'h00;
    end
    wr(iep_pkg::ADDR_PRIORITY, 8'h40);
    wr(iep_pkg::ADDR_ENABLE, 8'hDF);
    src_vec <= 8'h0A;
    cyc(4);
    cmp_req(1'b1, 1'b0, 3'h1);
    src_vec <= 8'h4A;
    cyc(4);
    cmp_req(1'b1, 1'b1, 3'h6);
    src_vec <= 8'h02;
    cyc(4);
    dly <= 4'($urandom % 4);
    auto_en <= 1'b1;
    cyc(10);
    cmp_req(1'b0, 1'b0, 3'h0);
    src_vec <= 8'h42;
    cyc(10);
    cmp_req(1'b0, 1'b0, 3'h0);
    auto_en <= 1'b0;
    rd(iep_pkg::ADDR_STATUS, 8'h07);
    reti();
    cyc(4);
    cmp_req(1'b1, 1'b1, 3'h6);
    src_vec <= 8'h00;
    reti();
    // Interrupt raised, masked, then cleared
    wr(iep_pkg::ADDR_MASK, 8'h04);
    cyc(3);
    cmp({7'h0, irq_out}, 8'h01);
    wr(iep_pkg::ADDR_MASK, 8'h00);
    cyc(3);
    cmp({7'h0, irq_out}, 8'h00);
    wr(iep_pkg::ADDR_MASK, 8'h07);
    wr(iep_pkg::ADDR_STATUS, 8'h07);
    cyc(3);
    cmp({7'h0, irq_out}, 8'h00);
    rd(iep_pkg::ADDR_STATUS, 8'h00);
    // Second reset in mid-run must clear the enable, priority and mask registers
    @(posedge sys_clk);
    resetn <= 1'b0;
    repeat (3) @(posedge sys_clk);
    resetn <= 1'b1;
    rd(iep_pkg::ADDR_ENABLE, 8'h00);
    rd(iep_pkg::ADDR_PRIORITY, 8'h00);
    rd(iep_pkg::ADDR_MASK, 8'h00);
    close_out();
  end
endmodule : iep_tb_top
`default_nettype wire
